//--- ucrm_params.svh
`ifndef UCRM_PARAMS_SVH
`define UCRM_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses on the three address lines
// ----------------------------------------------------------------
`define UCRM_ADR_DATA 3'h0
`define UCRM_ADR_IER 3'h1
`define UCRM_ADR_ISR 3'h2
`define UCRM_ADR_LCR 3'h3
`define UCRM_ADR_MCR 3'h4
`define UCRM_ADR_LSR 3'h5
`define UCRM_ADR_MSR 3'h6
`define UCRM_ADR_SPR 3'h7

// ----------------------------------------------------------------
// special values and field positions
// ----------------------------------------------------------------
`define UCRM_LCR_ENH 8'hBF
`define UCRM_LCR_DLAB 7
`define UCRM_FEATURE_CONTROL_SWAP 6
`define UCRM_EFR_ENH 4
`define UCRM_AFR_CONC 0
`define UCRM_MCR_LOOP 4
`define UCRM_ENHANCED_MODE_SELECT_CNT_TX 2'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UCRM_RST_ZERO 8'h00
`define UCRM_RST_SPR 8'hFF
`define UCRM_RST_ENHANCED_MODE_SELECT 8'h80

`endif

//--- ucrm_pkg.sv
package ucrm_pkg;

    // ----------------------------------------------------------------
    // register bank state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] line_control;
        logic [7:0] irq_enable;
        logic [7:0] modem_control;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic [7:0] alt_function;
        logic [7:0] scratch_pad;
        logic [7:0] enhanced_mode_select;
        logic [7:0] feature_control;
        logic [7:0] extra_function_reg;
        logic fifo_en;
        logic dma;
        logic [1:0] tx_trig;
        logic [1:0] rx_trig;
        logic [7:0] rdata;
        logic [7:0] tx_data;
        logic tx_load;
        logic rx_read;
        logic rx_rst;
        logic tx_rst;
    } ucrm_state_t;

    // ----------------------------------------------------------------
    // change detector state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic prev;
        logic armed;
        logic flag;
    } ucrm_delta_t;

endpackage : ucrm_pkg

//--- ucrm_sync.sv
`timescale 1ns/1ns

module ucrm_sync #(
    parameter int W = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    import ucrm_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // elaboration check on width
    if (W < 1) begin : g_chk
        $error("ucrm_sync width must be at least one");
    end

    // two flops, pins idle high
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : ucrm_sync

//--- ucrm_delta.sv
`timescale 1ns/1ns

module ucrm_delta (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic clear_i,
    output logic delta_o
);
    import ucrm_pkg::*;

    ucrm_delta_t q;
    ucrm_delta_t n;

    // sticky change flag, a change in the clear cycle wins
    always_comb begin
        n = q;
        n.prev = level_i;
        n.armed = 1'b1;
        if (clear_i) begin
            n.flag = 1'b0;
        end
        if (q.armed && (level_i != q.prev)) begin
            n.flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign delta_o = q.flag;

    a_delta_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (q.armed && (level_i != q.prev)) |=> delta_o)
        else $error("change of modem input not flagged");

endmodule : ucrm_delta

//--- ucrm_regs.sv
`timescale 1ns/1ns
`include "ucrm_params.svh"

// Operation
// - At address 000 with divisor access off, reads give the receive byte and writes load the transmit byte.
// - With divisor access on and line control not 0xBF, 000/001/010 reach divisor low, divisor high and alternate function; a zero divisor reads as the IDs.
// - At 111 with line control not 0xBF and feature bit 6 clear, a read/write scratch byte is kept.
// - At 111 with line control not 0xBF and feature bit 6 set, writes load enhanced mode select and reads return the FIFO level.
// - At 010 reads give interrupt status and writes set FIFO enable, resets, DMA mode and triggers.
// - Interrupt status shows the source code in bits 5:0 (5:4 enhanced only) and FIFO enable in 7:6.
// - Interrupt enable bits 3:0 gate receive, transmit empty, line status and modem status; 7:4 enhanced.
// - Line control holds word length, stop bits, parity enable, even, forced parity, break and divisor access.
// - Modem control drives terminal ready, request to send, user output two, loopback and enhanced modes.
// - Line status reports ready, overrun, parity, framing, break, holding empty, all empty and FIFO error.
// - Modem status 3:0 flag changes of clear-to-send, set-ready, ring and carrier; 7:4 give their state.
// - Alternate function holds concurrent write, baud clock select and receive-ready select; 7:3 reserved.
// - Enhanced mode select holds count select, direction inversion, hysteresis, error timing and sampling.
// - Enhanced-only bits are reachable only while the enhanced enable bit 4 is set, else read zero.
module ucrm_regs #(
    parameter logic CHANNEL_SEL = 1'b0,
    parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h5C // arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host bus
    input wire logic chip_sel_n_i,
    input wire logic channel_pick_i,
    input wire logic [2:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // datapath side
    input wire logic [7:0] rx_holding_i,
    output logic rx_read_o,
    output logic [7:0] tx_holding_o,
    output logic tx_load_o,
    input wire logic [5:0] irq_source_i,
    input wire logic [7:0] line_status_i,
    input wire logic [7:0] rx_count_i,
    input wire logic [7:0] tx_count_i,
    // configuration
    output logic [7:0] line_control_o,
    output logic [7:0] irq_enable_o,
    output logic [15:0] divisor_o,
    output logic fifo_enable_o,
    output logic rx_fifo_reset_o,
    output logic tx_fifo_reset_o,
    output logic dma_mode_o,
    output logic [1:0] tx_trigger_o,
    output logic [1:0] rx_trigger_o,
    output logic [7:0] alt_function_o,
    output logic [7:0] enhanced_mode_o,
    output logic [7:0] feature_control_o,
    output logic [7:0] extra_function_o,
    output logic loopback_o,
    output logic resume_on_any_char_o,
    output logic ir_mode_o,
    output logic prescaler_o,
    // modem pins
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic incoming_call_n_i,
    input wire logic carrier_n_i,
    output logic dtr_n_o,
    output logic request_send_out_n_o,
    output logic user_out_two_n_o
);
    import ucrm_pkg::*;

    ucrm_state_t q;
    ucrm_state_t n;
    logic enh_space;
    logic dlab;
    logic swap;
    logic efr_on;
    logic sel_hit;
    logic wr_hit;
    logic rd_hit;
    logic zero_div;
    logic msr_clear;
    logic [7:0] rd_val;
    logic [3:0] pin_sync;
    logic [3:0] modem_lvl;
    logic [3:0] modem_delta;

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------

    // mode selection from line control and feature bits
    assign enh_space = (q.line_control == `UCRM_LCR_ENH);
    assign dlab = q.line_control[`UCRM_LCR_DLAB] && !enh_space;
    assign swap = q.feature_control[`UCRM_FEATURE_CONTROL_SWAP];
    assign efr_on = q.extra_function_reg[`UCRM_EFR_ENH];
    assign zero_div = (q.dll == 8'h00) && (q.divisor_high == 8'h00);

    // channel pick; concurrent write lets either pick land here
    assign sel_hit = !chip_sel_n_i && (channel_pick_i == CHANNEL_SEL);
    assign wr_hit = wr_i && !chip_sel_n_i
        && ((channel_pick_i == CHANNEL_SEL) || q.alt_function[`UCRM_AFR_CONC]);
    assign rd_hit = rd_i && sel_hit;
    assign msr_clear = rd_hit && (addr_i == `UCRM_ADR_MSR) && !enh_space;

    // ----------------------------------------------------------------
    // modem inputs
    // ----------------------------------------------------------------

    // pins pass two flops first
    ucrm_sync #(
        .W(4)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({carrier_n_i, incoming_call_n_i, dsr_n_i, cts_n_i}),
        .sync_o(pin_sync)
    );

    // active-high levels, looped back from modem control in loopback
    always_comb begin
        if (q.modem_control[`UCRM_MCR_LOOP]) begin
            modem_lvl = {q.modem_control[3], q.modem_control[2], q.modem_control[0], q.modem_control[1]};
        end else begin
            modem_lvl = ~pin_sync;
        end
    end

    // one change detector per input
    for (genvar i = 0; i < 4; i++) begin : g_delta
        ucrm_delta u_delta (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .level_i(modem_lvl[i]),
            .clear_i(msr_clear),
            .delta_o(modem_delta[i])
        );
    end

    // ----------------------------------------------------------------
    // read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        unique case (addr_i)
            `UCRM_ADR_DATA: begin
                if (enh_space) begin
                    rd_val = 8'h00; // trigger/count space not held here
                end else if (dlab) begin
                    rd_val = zero_div ? REVISION_ID : q.dll;
                end else begin
                    rd_val = rx_holding_i;
                end
            end
            `UCRM_ADR_IER: begin
                if (enh_space) begin
                    rd_val = q.feature_control;
                end else if (dlab) begin
                    rd_val = zero_div ? DEVICE_ID : q.divisor_high;
                end else begin
                    rd_val = {efr_on ? q.irq_enable[7:4] : 4'h0, q.irq_enable[3:0]};
                end
            end
            `UCRM_ADR_ISR: begin
                if (enh_space) begin
                    rd_val = q.extra_function_reg;
                end else if (dlab) begin
                    rd_val = q.alt_function;
                end else begin
                    rd_val = {q.fifo_en, q.fifo_en,
                        efr_on ? irq_source_i[5:4] : 2'h0,
                        irq_source_i[3:0]};
                end
            end
            `UCRM_ADR_LCR: begin
                rd_val = q.line_control;
            end
            `UCRM_ADR_MCR: begin
                if (!enh_space) begin
                    rd_val = {efr_on ? q.modem_control[7:5] : 3'h0, q.modem_control[4:0]};
                end
            end
            `UCRM_ADR_LSR: begin
                if (!enh_space) begin
                    rd_val = line_status_i;
                end
            end
            `UCRM_ADR_MSR: begin
                if (!enh_space) begin
                    rd_val = {modem_lvl[3], modem_lvl[2], modem_lvl[1], modem_lvl[0],
                        modem_delta};
                end
            end
            `UCRM_ADR_SPR: begin
                if (enh_space) begin
                    rd_val = 8'h00;
                end else if (swap) begin
                    rd_val = (q.enhanced_mode_select[1:0] == `UCRM_ENHANCED_MODE_SELECT_CNT_TX) ?
                        tx_count_i : rx_count_i;
                end else begin
                    rd_val = q.scratch_pad;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        n.tx_load = 1'b0;
        n.rx_read = 1'b0;
        n.rx_rst = 1'b0;
        n.tx_rst = 1'b0;
        // register writes
        if (wr_hit) begin
            unique case (addr_i)
                `UCRM_ADR_DATA: begin
                    if (dlab) begin
                        n.dll = wdata_i;
                    end else if (!enh_space) begin
                        n.tx_data = wdata_i;
                        n.tx_load = 1'b1;
                    end
                end
                `UCRM_ADR_IER: begin
                    if (enh_space) begin
                        n.feature_control = wdata_i;
                    end else if (dlab) begin
                        n.divisor_high = wdata_i;
                    end else begin
                        n.irq_enable = {efr_on ? wdata_i[7:4] : 4'h0, wdata_i[3:0]};
                    end
                end
                `UCRM_ADR_ISR: begin
                    if (enh_space) begin
                        n.extra_function_reg = wdata_i;
                    end else if (dlab) begin
                        n.alt_function = {5'h00, wdata_i[2:0]};
                    end else begin
                        n.fifo_en = wdata_i[0];
                        n.rx_rst = wdata_i[1];
                        n.tx_rst = wdata_i[2];
                        n.dma = wdata_i[3];
                        n.tx_trig = efr_on ? wdata_i[5:4] : 2'h0;
                        n.rx_trig = wdata_i[7:6];
                    end
                end
                `UCRM_ADR_LCR: begin
                    n.line_control = wdata_i;
                end
                `UCRM_ADR_MCR: begin
                    if (!enh_space) begin
                        n.modem_control = {efr_on ? wdata_i[7:5] : 3'h0,
                            wdata_i[4:3], 1'b0, wdata_i[1:0]};
                    end
                end
                `UCRM_ADR_LSR: begin
                    n.tx_load = 1'b0; // writes here are ignored
                end
                `UCRM_ADR_MSR: begin
                    n.tx_load = 1'b0; // writes here are ignored
                end
                `UCRM_ADR_SPR: begin
                    if (!enh_space && swap) begin
                        n.enhanced_mode_select = {wdata_i[7:3], 1'b0, wdata_i[1:0]};
                    end else if (!enh_space) begin
                        n.scratch_pad = wdata_i;
                    end
                end
            endcase
        end
        // read data capture and read side effects
        if (rd_hit) begin
            n.rdata = rd_val;
            if ((addr_i == `UCRM_ADR_DATA) && !dlab && !enh_space) begin
                n.rx_read = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.scratch_pad <= `UCRM_RST_SPR;
            q.enhanced_mode_select <= `UCRM_RST_ENHANCED_MODE_SELECT;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // bus and datapath
    assign rdata_o = q.rdata;
    assign rx_read_o = q.rx_read;
    assign tx_holding_o = q.tx_data;
    assign tx_load_o = q.tx_load;

    // configuration fields
    assign line_control_o = q.line_control;
    assign irq_enable_o = q.irq_enable;
    assign divisor_o = {q.divisor_high, q.dll};
    assign fifo_enable_o = q.fifo_en;
    assign rx_fifo_reset_o = q.rx_rst;
    assign tx_fifo_reset_o = q.tx_rst;
    assign dma_mode_o = q.dma;
    assign tx_trigger_o = q.tx_trig;
    assign rx_trigger_o = q.rx_trig;
    assign alt_function_o = q.alt_function;
    assign enhanced_mode_o = q.enhanced_mode_select;
    assign feature_control_o = q.feature_control;
    assign extra_function_o = q.extra_function_reg;
    assign loopback_o = q.modem_control[`UCRM_MCR_LOOP];
    assign resume_on_any_char_o = q.modem_control[5];
    assign ir_mode_o = q.modem_control[6];
    assign prescaler_o = q.modem_control[7];

    // modem outputs, held inactive during loopback
    assign dtr_n_o = loopback_o || !q.modem_control[0];
    assign request_send_out_n_o = loopback_o || !q.modem_control[1];
    assign user_out_two_n_o = loopback_o || !q.modem_control[3];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_fcr_rx_reset;
        wr_hit && (addr_i == `UCRM_ADR_ISR) && !dlab && !enh_space && wdata_i[1];
    endsequence

    sequence s_one_pulse;
        rx_fifo_reset_o ##1 !rx_fifo_reset_o;
    endsequence

    sequence s_thr_write;
        wr_hit && (addr_i == `UCRM_ADR_DATA) && !q.line_control[`UCRM_LCR_DLAB];
    endsequence

    a_thr_load: assert property (
        s_thr_write |=> tx_load_o && (tx_holding_o == $past(wdata_i)) ##1 !tx_load_o)
        else $error("transmit byte not loaded");

    a_rhr_read: assert property (
        (rd_hit && (addr_i == `UCRM_ADR_DATA) && !q.line_control[`UCRM_LCR_DLAB])
        |=> rx_read_o && (rdata_o == $past(rx_holding_i)))
        else $error("receive byte not returned");

    a_div_high: assert property (
        (wr_hit && (addr_i == `UCRM_ADR_IER) && dlab)
        |=> (divisor_o[15:8] == $past(wdata_i)) && (irq_enable_o == $past(irq_enable_o)))
        else $error("divisor high byte not written");

    a_scratch_hold: assert property (
        (wr_hit && (addr_i == `UCRM_ADR_SPR) && !enh_space && !swap)
        ##1 (rd_hit && (addr_i == `UCRM_ADR_SPR) && !enh_space && !swap && !wr_hit)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("scratch byte lost");

    a_level_read: assert property (
        (rd_hit && (addr_i == `UCRM_ADR_SPR) && !enh_space && swap)
        |=> rdata_o == (($past(q.enhanced_mode_select[1:0]) == `UCRM_ENHANCED_MODE_SELECT_CNT_TX) ?
            $past(tx_count_i) : $past(rx_count_i)))
        else $error("fifo level not returned");

    a_fifo_reset: assert property (
        s_fcr_rx_reset |=> s_one_pulse)
        else $error("receive fifo reset not one pulse");

    a_status_fifo: assert property (
        (rd_hit && (addr_i == `UCRM_ADR_ISR) && !dlab && !enh_space)
        |=> (rdata_o[7:6] == {2{$past(fifo_enable_o)}}) && (rdata_o[3:0] == $past(irq_source_i[3:0])))
        else $error("interrupt status wrong");

    a_enh_hidden: assert property (
        (rd_hit && (addr_i == `UCRM_ADR_IER) && !dlab && !enh_space && !efr_on)
        |=> rdata_o[7:4] == 4'h0)
        else $error("enhanced enable bits visible");

    a_modem_out: assert property (
        (wr_hit && (addr_i == `UCRM_ADR_MCR) && !enh_space && !wdata_i[`UCRM_MCR_LOOP])
        |=> (dtr_n_o == !$past(wdata_i[0])) && (request_send_out_n_o == !$past(wdata_i[1])))
        else $error("modem outputs do not follow control");

    a_conc_write: assert property (
        (wr_i && !chip_sel_n_i && q.alt_function[`UCRM_AFR_CONC] && (addr_i == `UCRM_ADR_LCR))
        |=> line_control_o == $past(wdata_i))
        else $error("concurrent write missed");

endmodule : ucrm_regs

//--- ucrm_host.sv
`timescale 1ns/1ns

module ucrm_host (
    input wire logic sys_clk_i,
    output logic chip_sel_n_o,
    output logic channel_pick_o,
    output logic [2:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    // ----------------------------------------------------------------
    // host side of the register bus
    // ----------------------------------------------------------------
    // idle bus at time zero
    initial begin
        chip_sel_n_o = 1'b1;
        channel_pick_o = 1'b0;
        addr_o = 3'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // one strobe cycle, then release with inverted lines so stale values never match
    task automatic access(input logic w, input logic p, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_i);
        chip_sel_n_o <= 1'b0;
        channel_pick_o <= p;
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge sys_clk_i);
        chip_sel_n_o <= 1'b1;
        channel_pick_o <= !p;
        addr_o <= ~a;
        wdata_o <= ~d;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        @(negedge sys_clk_i);
        q = rdata_i;
    endtask : access
endmodule : ucrm_host

//--- uart_channel_register_map_test.sv
`timescale 1ns/1ns

module uart_channel_register_map_test;
    import ucrm_pkg::*;
    logic sys_clk_i, rst_n_i, cs_n, pick, wr, rd, cts_n, dsr_n, ri_n, cd_n;
    logic rxr, txl, fen, rxrst, txrst, dma, lpb, rany, irm, psc, dtr, rts, op2;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rxh, line_status, rxc, txc, txh, line_control, irq_enable, alt_function, emr, fct, extra_function_reg, q, d, e;
    logic [5:0] src;
    logic [15:0] dvs;
    logic [1:0] txt, rxt;
    int errors, tests_run, seed, cyc;

    ucrm_host h (.sys_clk_i(sys_clk_i), .chip_sel_n_o(cs_n), .channel_pick_o(pick),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));
    ucrm_regs #(.REVISION_ID(8'h3C)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .chip_sel_n_i(cs_n), .channel_pick_i(pick), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .rx_holding_i(rxh), .rx_read_o(rxr),
        .tx_holding_o(txh), .tx_load_o(txl), .irq_source_i(src), .line_status_i(line_status),
        .rx_count_i(rxc), .tx_count_i(txc), .line_control_o(line_control), .irq_enable_o(irq_enable),
        .divisor_o(dvs), .fifo_enable_o(fen), .rx_fifo_reset_o(rxrst),
        .tx_fifo_reset_o(txrst), .dma_mode_o(dma), .tx_trigger_o(txt), .rx_trigger_o(rxt),
        .alt_function_o(alt_function), .enhanced_mode_o(emr), .feature_control_o(fct),
        .extra_function_o(extra_function_reg), .loopback_o(lpb), .resume_on_any_char_o(rany),
        .ir_mode_o(irm), .prescaler_o(psc), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
        .incoming_call_n_i(ri_n), .carrier_n_i(cd_n), .dtr_n_o(dtr),
        .request_send_out_n_o(rts), .user_out_two_n_o(op2));

    // ----------------------------------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // hang guard, tests need well under 1000 cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask : chk

    task automatic wr8(input logic [2:0] a, input logic [7:0] v);
        h.access(1'b1, 1'b0, a, v, q);
    endtask : wr8

    task automatic rd8(input logic [2:0] a, input logic [7:0] x);
        h.access(1'b0, 1'b0, a, 8'h00, q);
        chk("rdata", {8'h00, x}, {8'h00, q});
    endtask : rd8

    // interrupt status: fifo flags on top, bits 5:4 only with enhanced on
    function automatic logic [7:0] exp_isr(input logic f, input logic [5:0] s, input logic en);
        return {f, f, en ? s[5:4] : 2'b00, s[3:0]};
    endfunction : exp_isr

    task automatic wrap_up();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        seed = 10712;
        {cts_n, dsr_n, ri_n, cd_n} = 4'hF;
        {rxh, line_status, rxc, txc, src} = '0;
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rxh <= 8'($random(seed));
        line_status <= 8'($random(seed));
        rxc <= 8'($random(seed));
        txc <= 8'($random(seed));
        src <= 6'($random(seed));
        @(negedge sys_clk_i);
        chk("modem outs", 16'h7, {dtr, rts, op2});
        rd8(3'h7, 8'hFF);
        rd8(3'h3, 8'h00);
        d = 8'($random(seed));
        wr8(3'h0, d);
        chk("tx", {7'h00, 1'b1, d}, {txl, txh});
        rd8(3'h0, rxh);
        chk("rx_read", 16'h1, rxr);
        $display("test data done");
        wr8(3'h3, 8'h80);
        rd8(3'h0, 8'h3C);
        e = 8'($random(seed)) | 8'h01;
        wr8(3'h0, d);
        wr8(3'h1, e);
        chk("divisor", {e, d}, dvs);
        rd8(3'h0, d);
        rd8(3'h1, e);
        wr8(3'h2, 8'hFF);
        rd8(3'h2, 8'h07);
        h.access(1'b1, 1'b1, 3'h1, ~e, q);
        chk("conc write", {~e, d}, dvs);
        wr8(3'h2, 8'h00);
        d = 8'($random(seed)) & 8'h7F;
        wr8(3'h3, d);
        chk("lcr", {8'h00, d}, line_control);
        $display("test divisor done");
        wr8(3'h7, e);
        h.access(1'b1, 1'b1, 3'h7, ~e, q);
        rd8(3'h7, e);
        wr8(3'h3, 8'h00);
        wr8(3'h1, 8'hFF);
        rd8(3'h1, 8'h0F);
        wr8(3'h2, 8'hF9);
        chk("fifo", 16'h0033, {fen, dma, txt, rxt});
        rd8(3'h2, exp_isr(1'b1, src, 1'b0));
        wr8(3'h2, 8'h07);
        chk("fifo reset", 16'h3, {rxrst, txrst});
        $display("test fifo done");
        wr8(3'h3, 8'hBF);
        wr8(3'h1, 8'h40);
        wr8(3'h2, 8'h10);
        rd8(3'h1, 8'h40);
        wr8(3'h3, 8'h00);
        wr8(3'h1, 8'hFF);
        rd8(3'h1, 8'hFF);
        rd8(3'h2, exp_isr(1'b1, src, 1'b1));
        wr8(3'h7, 8'hFF);
        chk("enhanced_mode_select", 16'h00FB, emr);
        rd8(3'h7, rxc);
        wr8(3'h7, 8'h01);
        rd8(3'h7, txc);
        $display("test enhanced done");
        wr8(3'h4, 8'h0F);
        chk("modem outs", 16'h0, {dtr, rts, op2});
        rd8(3'h4, 8'h0B);
        wr8(3'h4, 8'h13);
        chk("loopback", 16'hF, {lpb, dtr, rts, op2});
        wr8(3'h4, 8'h00);
        repeat (4) @(posedge sys_clk_i);
        h.access(1'b0, 1'b0, 3'h6, 8'h00, q);
        @(posedge sys_clk_i);
        cts_n <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        rd8(3'h6, 8'h11);
        rd8(3'h6, 8'h10);
        rd8(3'h5, line_status);
        wr8(3'h5, ~line_status);
        rd8(3'h5, line_status);
        $display("test status done");
        wrap_up();
    end
endmodule : uart_channel_register_map_test
